//--- rtl/nibble_add_instruction_unit.sv
// Operation
// - carry load, memory: acc gets mem + acc + carry; flags updated; one cycle.
// - carry load, immediate: acc gets wreg + imm + carry; wreg kept; flags updated.
// - carry store, memory: mem + acc + carry into acc and same location.
// - carry store, immediate: wreg + imm + carry into acc and that wreg.
// - plain add, memory: mem + acc, no carry-in, acc only, flags updated.
// - plain add, immediate: wreg + imm, no carry-in, acc only, flags updated.
// - store back, memory: mem + acc, no carry-in, into acc and memory.
// - store back, immediate: wreg + imm, no carry-in, into acc and wreg.
// - keep carry, memory: mem + acc into acc; carry untouched, zero updated.
// - immediate loads: 8-bit opcode, 4-bit immediate, 4-bit wreg selector.
// - immediate store forms use their own two 8-bit opcodes.
// - memory forms: 9-bit opcode prefix then 7-bit data address.
module nibble_add_instruction_unit
  import nibble_add_pkg::*;
#(
  parameter logic [OP9_W-1:0] OPC_MEM_PLAIN_ADD = OPC_MEM_PLAIN_ADD_DEF,
  parameter logic [OP9_W-1:0] OPC_MEM_KEEP_CARRY = OPC_MEM_KEEP_CARRY_DEF
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  output logic [ADDR_W-1:0] rd_addr_o,
  input wire logic [NIB_W-1:0] rd_data_i,
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_waddr_o,
  output logic [NIB_W-1:0] mem_wdata_o,
  output logic [NIB_W-1:0] result_o,
  output logic carry_flag_o,
  output logic zero_flag_o,
  output logic done_o,
  output logic unknown_o
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic [OP8_W-1:0] op8;
  logic [OP9_W-1:0] op9;
  decoded_t dec_nxt;
  decoded_t ex_r;
  logic ex_valid_r;
  logic unknown_nxt;
  logic unknown_r;

  assign op8 = instr_i[OP8_LSB +: OP8_W];
  assign op9 = instr_i[OP9_LSB +: OP9_W];

  always_comb begin
    dec_nxt.op = OP_NONE;
    dec_nxt.is_imm = 1'b0;
    dec_nxt.addr = instr_i[ADDR_LSB +: ADDR_W];
    dec_nxt.imm = instr_i[IMM_LSB +: NIB_W];
    unknown_nxt = 1'b0;
    if (op8 == OPC_IMM_CARRY_LOAD || op8 == OPC_IMM_PLAIN_ADD ||
        op8 == OPC_IMM_CARRY_STORE || op8 == OPC_IMM_STORE_BACK) begin
      dec_nxt.is_imm = 1'b1;
      dec_nxt.addr = WREG_BASE + ADDR_W'(instr_i[WSEL_LSB +: WSEL_W]);
      unique case (op8)
        OPC_IMM_CARRY_LOAD: dec_nxt.op = OP_CARRY_LOAD;
        OPC_IMM_PLAIN_ADD: dec_nxt.op = OP_PLAIN_ADD;
        OPC_IMM_CARRY_STORE: dec_nxt.op = OP_CARRY_STORE;
        default: dec_nxt.op = OP_STORE_BACK;
      endcase
    end else if (op9 == OPC_MEM_CARRY_LOAD) begin
      dec_nxt.op = OP_CARRY_LOAD;
    end else if (op9 == OPC_MEM_CARRY_STORE) begin
      dec_nxt.op = OP_CARRY_STORE;
    end else if (op9 == OPC_MEM_STORE_BACK) begin
      dec_nxt.op = OP_STORE_BACK;
    end else if (op9 == OPC_MEM_PLAIN_ADD) begin
      dec_nxt.op = OP_PLAIN_ADD;
    end else if (op9 == OPC_MEM_KEEP_CARRY) begin
      dec_nxt.op = OP_KEEP_CARRY;
    end else begin
      unknown_nxt = instr_valid_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ex_valid_r <= 1'b0;
      ex_r <= '{op: OP_NONE, is_imm: 1'b0, addr: ADDR_ZERO, imm: NIB_ZERO};
    end else begin
      ex_valid_r <= instr_valid_i && (dec_nxt.op != OP_NONE);
      ex_r <= dec_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      unknown_r <= 1'b0;
    end else begin
      unknown_r <= unknown_nxt;
    end
  end

  assign rd_addr_o = ex_r.addr;

  // ==========================================================================
  // Execute
  // ==========================================================================
  // The previous store is still in flight when the next add reads, so a
  // matching address takes the stored nibble instead of stale memory.
  mem_write_t wr_r;
  logic [NIB_W-1:0] operand;
  logic [NIB_W-1:0] opnd_b;
  logic cin;
  logic [NIB_W-1:0] sum;
  logic cout;
  logic [NIB_W-1:0] acc_r;
  logic cf_r;
  logic zf_r;
  logic done_r;
  logic is_store;

  assign operand = (wr_r.we && wr_r.addr == ex_r.addr) ? wr_r.data : rd_data_i;
  assign opnd_b = ex_r.is_imm ? ex_r.imm : acc_r;
  assign cin = (ex_r.op == OP_CARRY_LOAD || ex_r.op == OP_CARRY_STORE) ? cf_r : 1'b0;
  assign is_store = (ex_r.op == OP_CARRY_STORE || ex_r.op == OP_STORE_BACK);

  nibble_adder #(
    .W(NIB_W)
  ) u_adder (
    .a_i(operand),
    .b_i(opnd_b),
    .cin_i(cin),
    .sum_o(sum),
    .cout_o(cout)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      acc_r <= NIB_ZERO;
      zf_r <= 1'b0;
    end else if (ex_valid_r) begin
      acc_r <= sum;
      zf_r <= (sum == NIB_ZERO);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cf_r <= 1'b0;
    end else if (ex_valid_r && ex_r.op != OP_KEEP_CARRY) begin
      cf_r <= cout;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wr_r <= '{we: 1'b0, addr: ADDR_ZERO, data: NIB_ZERO};
    end else begin
      wr_r.we <= ex_valid_r && is_store;
      wr_r.addr <= ex_r.addr;
      wr_r.data <= sum;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= ex_valid_r;
    end
  end

  assign mem_we_o = wr_r.we;
  assign mem_waddr_o = wr_r.addr;
  assign mem_wdata_o = wr_r.data;
  assign result_o = acc_r;
  assign carry_flag_o = cf_r;
  assign zero_flag_o = zf_r;
  assign done_o = done_r;
  assign unknown_o = unknown_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_exec(add_op_t o, logic imm);
    ex_valid_r && ex_r.op == o && ex_r.is_imm == imm;
  endsequence

  sequence s_store_issue;
    ex_valid_r && is_store;
  endsequence

  a_carry_load_mem: assert property (
    s_exec(OP_CARRY_LOAD, 1'b0) |=> result_o == 4'($past(operand) + $past(acc_r) + {3'b000, $past(cf_r)})
      && !mem_we_o)
    else $error("carry load from memory gave a wrong result");

  a_carry_load_imm: assert property (
    s_exec(OP_CARRY_LOAD, 1'b1) |=> result_o == 4'($past(operand) + $past(ex_r.imm) + {3'b000, $past(cf_r)})
      && !mem_we_o)
    else $error("carry load immediate gave a wrong result or wrote back");

  a_carry_store_mem: assert property (
    s_exec(OP_CARRY_STORE, 1'b0) |=> mem_we_o && mem_wdata_o == result_o && mem_waddr_o == $past(ex_r.addr))
    else $error("carry store did not write the sum back to memory");

  a_carry_store_imm: assert property (
    s_exec(OP_CARRY_STORE, 1'b1) |=> mem_we_o && mem_waddr_o == $past(ex_r.addr)
      && mem_wdata_o == 4'($past(operand) + $past(ex_r.imm) + {3'b000, $past(cf_r)}))
    else $error("carry store immediate did not update the working register");

  a_plain_add_mem: assert property (
    s_exec(OP_PLAIN_ADD, 1'b0) |=> result_o == 4'($past(operand) + $past(acc_r)) && !mem_we_o
      && carry_flag_o == (5'($past(operand)) + 5'($past(acc_r)) > 5'h0F))
    else $error("plain add used a carry in or wrote memory");

  a_plain_add_imm: assert property (
    s_exec(OP_PLAIN_ADD, 1'b1) |=> result_o == 4'($past(operand) + $past(ex_r.imm)) && !mem_we_o)
    else $error("plain add immediate gave a wrong result");

  a_store_back_mem: assert property (
    s_exec(OP_STORE_BACK, 1'b0) |=> mem_we_o && mem_wdata_o == 4'($past(operand) + $past(acc_r)))
    else $error("store back to memory gave a wrong nibble");

  a_store_back_imm: assert property (
    s_exec(OP_STORE_BACK, 1'b1) |=> mem_we_o && result_o == mem_wdata_o
      && mem_wdata_o == 4'($past(operand) + $past(ex_r.imm)))
    else $error("store back immediate gave a wrong nibble");

  a_keep_carry: assert property (
    s_exec(OP_KEEP_CARRY, 1'b0) |=> $stable(carry_flag_o) && !mem_we_o
      && result_o == 4'($past(operand) + $past(acc_r)))
    else $error("keep carry add changed the carry flag");

  a_zero_flag: assert property (
    ex_valid_r |=> zero_flag_o == (result_o == NIB_ZERO))
    else $error("zero flag does not match the result");

  a_imm_decode: assert property (
    instr_valid_i && op8 == OPC_IMM_CARRY_LOAD |=> ex_valid_r && ex_r.is_imm
      && ex_r.op == OP_CARRY_LOAD && ex_r.imm == $past(instr_i[IMM_LSB +: NIB_W]))
    else $error("immediate carry load decoded wrongly");

  a_store_pulse: assert property (
    s_store_issue |=> mem_we_o ##1 (!mem_we_o || $past(ex_valid_r && is_store)))
    else $error("memory write strobe lasted beyond its instruction");

  a_imm_store_decode: assert property (
    instr_valid_i && op8 == OPC_IMM_STORE_BACK |=> ex_valid_r && ex_r.is_imm && ex_r.op == OP_STORE_BACK
      && ex_r.addr == WREG_BASE + ADDR_W'($past(instr_i[WSEL_LSB +: WSEL_W])))
    else $error("immediate store back decoded wrongly");

  a_mem_decode: assert property (
    instr_valid_i && op9 == OPC_MEM_STORE_BACK |=> ex_valid_r && !ex_r.is_imm
      && ex_r.addr == $past(instr_i[ADDR_LSB +: ADDR_W]))
    else $error("memory store back decoded wrongly");

endmodule : nibble_add_instruction_unit

//--- rtl/nibble_add_pkg.sv
package nibble_add_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned NIB_W = 4;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned OP8_W = 8;
  localparam int unsigned OP9_W = 9;
  localparam int unsigned WSEL_W = 4;

  // ==========================================================================
  // Instruction word fields
  // ==========================================================================
  localparam int unsigned OP8_LSB = 8;
  localparam int unsigned OP9_LSB = 7;
  localparam int unsigned IMM_LSB = 4;
  localparam int unsigned WSEL_LSB = 0;
  localparam int unsigned ADDR_LSB = 0;

  // ==========================================================================
  // Opcodes
  // ==========================================================================
  localparam logic [OP8_W-1:0] OPC_IMM_CARRY_LOAD = 8'h0C;
  localparam logic [OP8_W-1:0] OPC_IMM_PLAIN_ADD = 8'h1C;
  localparam logic [OP8_W-1:0] OPC_IMM_CARRY_STORE = 8'h0D;
  localparam logic [OP8_W-1:0] OPC_IMM_STORE_BACK = 8'h1D;
  localparam logic [OP9_W-1:0] OPC_MEM_CARRY_LOAD = 9'h020;
  localparam logic [OP9_W-1:0] OPC_MEM_CARRY_STORE = 9'h012;
  localparam logic [OP9_W-1:0] OPC_MEM_STORE_BACK = 9'h032;
  // Provisional prefixes; see module parameters.
  localparam logic [OP9_W-1:0] OPC_MEM_PLAIN_ADD_DEF = 9'h030;
  localparam logic [OP9_W-1:0] OPC_MEM_KEEP_CARRY_DEF = 9'h050;

  // Working registers live at the bottom of data memory.
  localparam logic [ADDR_W-1:0] WREG_BASE = 7'h00;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_CARRY_LOAD = 3'b001,
    OP_CARRY_STORE = 3'b010,
    OP_PLAIN_ADD = 3'b011,
    OP_STORE_BACK = 3'b100,
    OP_KEEP_CARRY = 3'b101
  } add_op_t;

  typedef struct packed {
    add_op_t op;
    logic is_imm;
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0] imm;
  } decoded_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0] data;
  } mem_write_t;

endpackage : nibble_add_pkg

//--- rtl/nibble_adder.sv
module nibble_adder #(
  parameter int unsigned W = 4
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic cin_i,
  output logic [W-1:0] sum_o,
  output logic cout_o
);

  logic [W:0] full;

  assign full = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, cin_i};
  assign sum_o = full[W-1:0];
  assign cout_o = full[W];

endmodule : nibble_adder

//--- tb/testbench.sv
module testbench
  import nibble_add_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = 16'h0000;
  logic [NIB_W-1:0] rd_data_i;
  logic [ADDR_W-1:0] rd_addr_o, mem_waddr_o;
  logic [NIB_W-1:0] mem_wdata_o, result_o;
  logic mem_we_o, carry_flag_o, zero_flag_o, done_o, unknown_o;
  logic [NIB_W-1:0] mem_m [128];
  logic [NIB_W-1:0] mem_e [128];
  logic [NIB_W-1:0] acc_m;
  logic cf_m, zf_m;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  nibble_add_instruction_unit u_nibble_add_instruction_unit (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .result_o(result_o),
    .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o), .done_o(done_o), .unknown_o(unknown_o));

  // ==========================================================================
  // Clock, data memory and watchdog
  // ==========================================================================
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // The memory answers combinationally, as the execute stage expects.
  assign rd_data_i = mem_m[rd_addr_o];

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (mem_we_o === 1'b1) begin
      mem_m[mem_waddr_o] <= mem_wdata_o;
    end
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Returns the operation code 1..5, plus 8 for the immediate forms; 0 for a non-add word.
  function automatic int kind(input logic [15:0] w);
    case (w[15:8])
      OPC_IMM_CARRY_LOAD: return 9;
      OPC_IMM_CARRY_STORE: return 10;
      OPC_IMM_PLAIN_ADD: return 11;
      OPC_IMM_STORE_BACK: return 12;
      default: ;
    endcase
    case (w[15:7])
      OPC_MEM_CARRY_LOAD: return 1;
      OPC_MEM_CARRY_STORE: return 2;
      OPC_MEM_PLAIN_ADD_DEF: return 3;
      OPC_MEM_STORE_BACK: return 4;
      OPC_MEM_KEEP_CARRY_DEF: return 5;
      default: return 0;
    endcase
  endfunction : kind

  // Works out one instruction and advances the model, so a second word can be predicted before the first retires.
  task automatic predict(input logic [15:0] w, output int op, output logic [6:0] a, output logic [4:0] s);
    int k;
    k = kind(w);
    op = k % 8;
    a = (k >= 8) ? WREG_BASE + 7'(w[3:0]) : w[6:0];
    s = 5'(mem_e[a]) + ((k >= 8) ? 5'(w[7:4]) : 5'(acc_m)) + 5'((op == 1 || op == 2) ? cf_m : 1'b0);
    if (op != 0) begin
      acc_m = s[3:0];
      cf_m = (op == 5) ? cf_m : s[4];
      zf_m = (s[3:0] == 4'h0);
    end
    if (op == 2 || op == 4) begin
      mem_e[a] = s[3:0];
    end
  endtask : predict

  task automatic check_out(input int op, input logic [6:0] a, input logic [4:0] s, input logic unk,
                           input logic [5:0] st);
    chk(8'(unk), 8'(op == 0), "unknown pulse");
    chk(8'(done_o), 8'(op != 0), "done pulse");
    chk(8'(result_o), 8'(st[5:2]), "result");
    chk(8'(carry_flag_o), 8'(st[1]), "carry");
    chk(8'(zero_flag_o), 8'(st[0]), "zero");
    chk(8'(mem_we_o), 8'(op == 2 || op == 4), "write strobe");
    if (op == 2 || op == 4) begin
      chk({1'b0, mem_waddr_o}, 8'(a), "write address");
      chk(8'(mem_wdata_o), 8'(s[3:0]), "write data");
    end
  endtask : check_out

  task automatic run(input logic [15:0] w);
    int op;
    logic [6:0] a;
    logic [4:0] s;
    logic unk;
    predict(w, op, a, s);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    instr_i <= 16'($urandom);
    #1;
    if (op != 0) chk(8'(rd_addr_o), 8'(a), "read address");
    unk = unknown_o;
    @(posedge clk_sys_i);
    #1;
    check_out(op, a, s, unk | unknown_o, {acc_m, cf_m, zf_m});
  endtask : run

  // Two words on consecutive edges: the second reads while the first store is still in flight.
  task automatic run_pair(input logic [15:0] w0, input logic [15:0] w1);
    int op0;
    int op1;
    logic [6:0] a0;
    logic [6:0] a1;
    logic [4:0] s0;
    logic [4:0] s1;
    logic [5:0] st0;
    logic [5:0] st1;
    logic unk0;
    logic unk1;
    predict(w0, op0, a0, s0);
    st0 = {acc_m, cf_m, zf_m};
    predict(w1, op1, a1, s1);
    st1 = {acc_m, cf_m, zf_m};
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= w0;
    @(posedge clk_sys_i);
    instr_i <= w1;
    #1;
    if (op0 != 0) chk(8'(rd_addr_o), 8'(a0), "pair read address");
    unk0 = unknown_o;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    instr_i <= 16'($urandom);
    #1;
    if (op1 != 0) chk(8'(rd_addr_o), 8'(a1), "pair second read address");
    unk1 = unknown_o;
    check_out(op0, a0, s0, unk0, st0);
    @(posedge clk_sys_i);
    #1;
    check_out(op1, a1, s1, unk1, st1);
  endtask : run_pair

  function automatic logic [15:0] rand_word();
    logic [15:0] r;
    r = 16'($urandom);
    case ($urandom_range(0, 9))
      0: return {OPC_IMM_CARRY_LOAD, r[7:0]};
      1: return {OPC_IMM_CARRY_STORE, r[7:0]};
      2: return {OPC_IMM_PLAIN_ADD, r[7:0]};
      3: return {OPC_IMM_STORE_BACK, r[7:0]};
      4: return {OPC_MEM_CARRY_LOAD, r[6:0]};
      5: return {OPC_MEM_CARRY_STORE, r[6:0]};
      6: return {OPC_MEM_PLAIN_ADD_DEF, r[6:0]};
      7: return {OPC_MEM_STORE_BACK, r[6:0]};
      8: return {OPC_MEM_KEEP_CARRY_DEF, r[6:0]};
      default: return {8'h2C, r[7:0]};
    endcase
  endfunction : rand_word

  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    #1;
    acc_m = 4'h0;
    cf_m = 1'b0;
    zf_m = 1'b0;
    chk({result_o, carry_flag_o, zero_flag_o, done_o, mem_we_o}, 8'h00, "reset state");
  endtask : do_reset

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [15:0] pw0;
    logic [15:0] pw1;
    void'($urandom(11));
    for (int i = 0; i < 128; i++) begin
      mem_m[i] = 4'($urandom);
      mem_e[i] = mem_m[i];
    end
    do_reset();
    // Overflow to zero, then a keep-carry add must hold the carry it produced.
    mem_m[3] = 4'hF; mem_e[3] = 4'hF; mem_m[4] = 4'h1; mem_e[4] = 4'h1; mem_m[5] = 4'h0; mem_e[5] = 4'h0;
    run({OPC_MEM_PLAIN_ADD_DEF, 7'h03});
    run({OPC_MEM_CARRY_LOAD, 7'h04});
    run({OPC_MEM_KEEP_CARRY_DEF, 7'h05});
    run({OPC_IMM_CARRY_STORE, 4'hF, 4'h5});
    run({8'h2C, 4'h1, 4'h2});
    $display("directed corner test done");
    for (int i = 0; i < 400; i++) begin
      run(rand_word());
    end
    $display("random test done");
    // A store followed at once by a read of the same nibble, through memory and through a working register.
    run_pair({OPC_MEM_STORE_BACK, 7'h05}, {OPC_MEM_PLAIN_ADD_DEF, 7'h05});
    run_pair({OPC_IMM_STORE_BACK, 4'h3, 4'h2}, {OPC_MEM_CARRY_LOAD, 7'h02});
    run_pair({OPC_MEM_CARRY_STORE, 7'h07}, {OPC_IMM_PLAIN_ADD, 4'h9, 4'h7});
    for (int i = 0; i < 100; i++) begin
      pw0 = rand_word();
      pw1 = rand_word();
      run_pair(pw0, {pw1[15:4], pw0[3:0]});
    end
    $display("back to back test done");
    do_reset();
    for (int i = 0; i < 50; i++) begin
      run(rand_word());
    end
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 128; i++) begin
      chk(8'(mem_m[i]), 8'(mem_e[i]), "memory contents");
    end
    $display("reset and memory test done");
    finish_test();
  end
endmodule : testbench
